// *** src/platform_id_command_responder.sv ***
// identification command responder behind the management bus slave engine
`timescale 1ns/10ps
// Operation
// - read word at command fc returns the fixed identification word as two bytes
// - the identification word is two bytes, unsigned binary, low byte first
// - write word to fc is acknowledged and its data thrown away
// - block read at command fd returns the fixed identification block
// - the block holds exactly six unsigned bytes behind its count byte
// - block write to fd is acknowledged and its bytes thrown away
// - after any write, reads return the same hard-wired values
// - writes to either command never raise a communication error
// - six hard-wired bytes; bits 47:40 most significant, 7:0 least
// - no paging and no nonvolatile copy of either command
// - all sixteen word bits are read-only constants
module platform_id_command_responder #(
  parameter logic [15:0] ID_WORD = 16'h1234, // arbitrary value
  parameter logic [47:0] ID_BLOCK = 48'h0a0b0c0d0e0f // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_slave_addr,
  input wire platform_id_pkg::bus_event_type i_event,
  output platform_id_pkg::answer_type o_answer
);

  // the byte index must be able to pass the last block byte
  if (platform_id_pkg::ID_BLOCK_BYTES >= int'(platform_id_pkg::IDX_MAX))
  begin : g_idx_check
    $error("byte index too narrow for the identification block");
  end

  typedef struct packed {
    platform_id_pkg::phase_type phase;
    platform_id_pkg::sel_type sel;
    logic [2:0] idx;
    platform_id_pkg::answer_type ans;
  } state_type;

  localparam state_type RESET_STATE = '{
    phase: platform_id_pkg::PH_IDLE,
    sel: platform_id_pkg::SEL_NONE,
    idx: platform_id_pkg::IDX_FIRST,
    ans: '0
  };

  state_type st;
  state_type next_st;
  logic [7:0] rom_byte;
  logic rom_past_end;
  logic addr_match;
  logic ev_start;
  logic ev_write;
  logic ev_read;
  logic ev_stop;

  // constants only, so nothing a host writes can reach them
  id_byte_rom #(
    .ID_WORD(ID_WORD),
    .ID_BLOCK(ID_BLOCK)
  ) u_rom (
    .i_sel(st.sel),
    .i_idx(st.idx),
    .o_byte(rom_byte),
    .o_past_end(rom_past_end)
  );

  // event decode; the slave engine shares our clock, so no synchroniser
  assign ev_start = i_event.valid && i_event.kind == platform_id_pkg::EV_START;
  assign ev_write = i_event.valid && i_event.kind == platform_id_pkg::EV_WRITE;
  assign ev_read = i_event.valid && i_event.kind == platform_id_pkg::EV_READ;
  assign ev_stop = i_event.valid && i_event.kind == platform_id_pkg::EV_STOP;
  assign addr_match =
    i_event.data[platform_id_pkg::ADDR_MSB:platform_id_pkg::ADDR_LSB]
    == i_slave_addr;

  // transaction sequencing; ack, rd_valid and cml_err are one-cycle pulses, claim follows the phase
  always_comb
  begin
    next_st = st;
    next_st.ans.ack = 1'b0;
    next_st.ans.rd_valid = 1'b0;
    next_st.ans.cml_err = 1'b0;
    if (ev_start)
    begin
      if (!addr_match)
      begin
        next_st.phase = platform_id_pkg::PH_IGNORE;
        next_st.sel = platform_id_pkg::SEL_NONE;
      end
      else if (!i_event.data[platform_id_pkg::RW_BIT])
      begin
        next_st.phase = platform_id_pkg::PH_AWAIT_CMD;
        next_st.sel = platform_id_pkg::SEL_NONE;
        next_st.idx = platform_id_pkg::IDX_FIRST;
        next_st.ans.ack = 1'b1;
      end
      else if (st.phase == platform_id_pkg::PH_CMD_HELD)
      begin
        // repeated start turning a command into a read
        next_st.phase = platform_id_pkg::PH_READING;
        next_st.idx = platform_id_pkg::IDX_FIRST;
        next_st.ans.ack = 1'b1;
      end
      else
      begin
        next_st.phase = platform_id_pkg::PH_IGNORE;
      end
    end
    else if (ev_write)
    begin
      if (st.phase == platform_id_pkg::PH_AWAIT_CMD)
      begin
        // other command codes belong to other responders
        if (i_event.data == platform_id_pkg::CMD_ID_WORD)
        begin
          next_st.sel = platform_id_pkg::SEL_WORD;
          next_st.phase = platform_id_pkg::PH_CMD_HELD;
          next_st.ans.ack = 1'b1;
        end
        else if (i_event.data == platform_id_pkg::CMD_ID_BLOCK)
        begin
          next_st.sel = platform_id_pkg::SEL_BLOCK;
          next_st.phase = platform_id_pkg::PH_CMD_HELD;
          next_st.ans.ack = 1'b1;
        end
        else
        begin
          next_st.phase = platform_id_pkg::PH_IGNORE;
        end
      end
      else if (st.phase == platform_id_pkg::PH_CMD_HELD)
      begin
        // data, counts of any length, all acknowledged and dropped
        next_st.ans.ack = 1'b1;
      end
    end
    else if (ev_read)
    begin
      if (st.phase == platform_id_pkg::PH_READING)
      begin
        next_st.ans.rd_valid = 1'b1;
        next_st.ans.rd_data = rom_byte;
        // only an overrun read flags an error, never a write
        next_st.ans.cml_err = rom_past_end;
        if (st.idx != platform_id_pkg::IDX_MAX)
        begin
          next_st.idx = st.idx + platform_id_pkg::IDX_STEP;
        end
      end
    end
    else if (ev_stop)
    begin
      next_st.phase = platform_id_pkg::PH_IDLE;
      next_st.sel = platform_id_pkg::SEL_NONE;
      next_st.idx = platform_id_pkg::IDX_FIRST;
    end
    next_st.ans.claim = next_st.phase == platform_id_pkg::PH_CMD_HELD
      || next_st.phase == platform_id_pkg::PH_READING;
  end

  // single state register, synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st <= RESET_STATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_answer = st.ans;

  // helper: block byte the current index must produce
  logic [7:0] exp_block_byte;
  always_comb
  begin
    exp_block_byte = ID_BLOCK[8*(st.idx - platform_id_pkg::IDX_STEP) +: 8];
  end

  logic read_word_lo;
  logic read_word_hi;
  logic read_blk_cnt;
  logic read_blk_data;
  assign read_word_lo = ev_read && st.phase == platform_id_pkg::PH_READING
    && st.sel == platform_id_pkg::SEL_WORD && st.idx == 3'h0;
  assign read_word_hi = ev_read && st.phase == platform_id_pkg::PH_READING
    && st.sel == platform_id_pkg::SEL_WORD && st.idx == 3'h1;
  assign read_blk_cnt = ev_read && st.phase == platform_id_pkg::PH_READING
    && st.sel == platform_id_pkg::SEL_BLOCK && st.idx == 3'h0;
  assign read_blk_data = ev_read && st.phase == platform_id_pkg::PH_READING
    && st.sel == platform_id_pkg::SEL_BLOCK && st.idx >= 3'h1
    && st.idx <= 3'h6;

  // first word byte is bits 7:0
  AST_WORD_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    read_word_lo |=> o_answer.rd_valid && o_answer.rd_data == ID_WORD[7:0])
    else $error("word low byte wrong");

  // second word byte is bits 15:8, then the index has moved past the word
  AST_WORD_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    read_word_hi |=> o_answer.rd_valid && o_answer.rd_data == ID_WORD[15:8]
      && !o_answer.cml_err && st.idx == 3'h2)
    else $error("word high byte wrong");

  // write data to a held command is acknowledged and changes nothing
  AST_WRITE_DISCARD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_write && st.phase == platform_id_pkg::PH_CMD_HELD)
      |=> o_answer.ack && st.phase == platform_id_pkg::PH_CMD_HELD
      && st.sel == $past(st.sel) && st.idx == $past(st.idx))
    else $error("write to identification command not discarded");

  // block data bytes follow from the constant, low byte first
  AST_BLOCK_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    read_blk_data |=> o_answer.rd_valid
      && o_answer.rd_data == $past(exp_block_byte))
    else $error("block byte wrong");

  // block starts with a count of six
  AST_BLOCK_COUNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    read_blk_cnt |=> o_answer.rd_data == 8'h06 && !o_answer.cml_err)
    else $error("block count wrong");

  // a seventh data read overruns the block
  AST_BLOCK_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_read && st.phase == platform_id_pkg::PH_READING
      && st.sel == platform_id_pkg::SEL_BLOCK && st.idx == 3'h7)
      |=> o_answer.cml_err && o_answer.rd_data == platform_id_pkg::PAD_BYTE)
    else $error("block overrun not flagged");

  // last block byte carries bits 47:40
  AST_BLOCK_MSB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (read_blk_data && st.idx == 3'h6) |=> o_answer.rd_data == ID_BLOCK[47:40])
    else $error("block top byte wrong");

  // a write never raises the error pulse
  AST_NO_CML_ON_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ev_write |=> !o_answer.cml_err)
    else $error("communication error after write");

  // a read after writes still starts with the fixed values
  AST_READ_AFTER_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_write && st.phase == platform_id_pkg::PH_CMD_HELD)
      ##1 (ev_start && addr_match && i_event.data[0]) ##1 read_word_lo
      |=> o_answer.rd_data == ID_WORD[7:0])
    else $error("readback changed after write");

  // a foreign address is neither acknowledged nor claimed
  AST_FOREIGN_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_start && !addr_match)
      |=> !o_answer.ack && !o_answer.claim
      && st.phase == platform_id_pkg::PH_IGNORE)
    else $error("foreign address answered");

  // an ignored transaction stays silent until stop or a write-direction start to our address
  AST_IGNORE_SILENT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.phase == platform_id_pkg::PH_IGNORE && i_event.valid
      && i_event.kind != platform_id_pkg::EV_START)
      |=> !o_answer.ack && !o_answer.rd_valid)
    else $error("ignored transaction answered");

  // our address with a write direction is acknowledged, nothing claimed yet
  AST_ADDR_ACK: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (ev_start && addr_match && !i_event.data[platform_id_pkg::RW_BIT])
      |=> o_answer.ack && !o_answer.claim)
    else $error("own address not acknowledged");

  // a known command byte is acknowledged and claims the transaction
  AST_CMD_TAKEN: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (ev_write && st.phase == platform_id_pkg::PH_AWAIT_CMD
      && (i_event.data == platform_id_pkg::CMD_ID_WORD
      || i_event.data == platform_id_pkg::CMD_ID_BLOCK))
      |=> o_answer.ack && o_answer.claim)
    else $error("identification command not taken");

  // a repeated start for reading begins at the first reply byte
  AST_READ_ENTRY: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (ev_start && addr_match && i_event.data[platform_id_pkg::RW_BIT]
      && st.phase == platform_id_pkg::PH_CMD_HELD)
      |=> o_answer.ack && o_answer.claim
      && st.idx == platform_id_pkg::IDX_FIRST)
    else $error("read entry wrong");

  // the word is only two bytes long; further reads pad and flag
  AST_WORD_OVERRUN: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (ev_read && st.phase == platform_id_pkg::PH_READING
      && st.sel == platform_id_pkg::SEL_WORD && st.idx >= 3'h2)
      |=> o_answer.rd_valid && o_answer.cml_err
      && o_answer.rd_data == platform_id_pkg::PAD_BYTE)
    else $error("word overrun not flagged");

  // stop always ends the transaction and drops the claim
  AST_STOP_RELEASE: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    ev_stop |=> !o_answer.claim && !o_answer.ack
      && st.phase == platform_id_pkg::PH_IDLE)
    else $error("stop did not end the transaction");

  // the selected command cannot change while it is held or read
  AST_SEL_HELD: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (o_answer.claim && !ev_start && !ev_stop) |=> $stable(st.sel))
    else $error("selected command changed mid transaction");

  // writes never produce reply data
  AST_WRITE_NO_READ: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    ev_write |=> !o_answer.rd_valid)
    else $error("reply data after write");

  // main scenarios the bench is expected to reach
  COV_WORD_READ: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    read_word_lo ##[1:4] read_word_hi);
  COV_BLOCK_LAST: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    read_blk_data && st.idx == 3'h6);
  COV_WRITE_DROP: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    ev_write && st.phase == platform_id_pkg::PH_CMD_HELD
    && st.sel == platform_id_pkg::SEL_BLOCK);
  COV_FOREIGN: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    ev_start && !addr_match);

endmodule // platform_id_command_responder

// *** src/platform_id_pkg.sv ***
// constants, enumerations and carriers shared by the identification responder
package platform_id_pkg;

  // command codes served by the responder
  localparam logic [7:0] CMD_ID_WORD = 8'hfc;
  localparam logic [7:0] CMD_ID_BLOCK = 8'hfd;

  // payload sizes in bytes
  localparam int ID_WORD_BYTES = 2;
  localparam int ID_BLOCK_BYTES = 6;
  localparam logic [7:0] BLOCK_COUNT = 8'h06;

  // byte returned when the host reads past the end of a reply
  localparam logic [7:0] PAD_BYTE = 8'hff;

  // address byte layout on a start event
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RW_BIT = 0;

  // reply byte index width and its saturation value
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_FIRST = 3'h0;
  localparam logic [2:0] IDX_STEP = 3'h1;
  localparam logic [2:0] IDX_MAX = 3'h7;

  // bus events handed over by the slave engine
  typedef enum logic [1:0] {
    EV_START = 2'h0,
    EV_WRITE = 2'h1,
    EV_READ = 2'h2,
    EV_STOP = 2'h3
  } event_kind_type;

  // which identification command the transaction selected
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_WORD = 2'h1,
    SEL_BLOCK = 2'h2
  } sel_type;

  // transaction phase, gray coded along idle-address-command-read
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_AWAIT_CMD = 3'h1,
    PH_CMD_HELD = 3'h3,
    PH_READING = 3'h2,
    PH_IGNORE = 3'h6
  } phase_type;

  typedef struct packed {
    logic valid;
    event_kind_type kind;
    logic [7:0] data;
  } bus_event_type;

  typedef struct packed {
    logic ack;
    logic rd_valid;
    logic [7:0] rd_data;
    logic cml_err;
    logic claim;
  } answer_type;

endpackage

// *** src/id_byte_rom.sv ***
// hard-wired identification bytes, selected by command and byte index
`timescale 1ns/10ps
module id_byte_rom #(
  parameter logic [15:0] ID_WORD = 16'h1234,
  parameter logic [47:0] ID_BLOCK = 48'h0a0b0c0d0e0f
) (
  input wire platform_id_pkg::sel_type i_sel,
  input wire logic [2:0] i_idx,
  output logic [7:0] o_byte,
  output logic o_past_end
);

  // word goes low byte first; block goes count, then bits 7:0 up to 47:40
  always_comb
  begin
    o_byte = platform_id_pkg::PAD_BYTE;
    o_past_end = 1'b1;
    unique case (i_sel)
      platform_id_pkg::SEL_WORD:
      begin
        if (int'(i_idx) < platform_id_pkg::ID_WORD_BYTES)
        begin
          o_byte = ID_WORD[8*i_idx +: 8];
          o_past_end = 1'b0;
        end
      end
      platform_id_pkg::SEL_BLOCK:
      begin
        if (i_idx == platform_id_pkg::IDX_FIRST)
        begin
          o_byte = platform_id_pkg::BLOCK_COUNT;
          o_past_end = 1'b0;
        end
        else if (int'(i_idx) <= platform_id_pkg::ID_BLOCK_BYTES)
        begin
          o_byte = ID_BLOCK[8*(i_idx - platform_id_pkg::IDX_STEP) +: 8];
          o_past_end = 1'b0;
        end
      end
      default:
      begin
        o_byte = platform_id_pkg::PAD_BYTE;
        o_past_end = 1'b1;
      end
    endcase
  end

endmodule // id_byte_rom

// *** tb/host_event_model.sv ***
// host-side model that issues slave engine events to the responder
`timescale 1ns/10ps
module host_event_model (
  input wire logic i_clk,
  input wire platform_id_pkg::answer_type i_answer,
  output platform_id_pkg::bus_event_type o_event
);
  platform_id_pkg::answer_type last_answer;

  // idle bus at time zero
  initial
  begin
    o_event = '0;
    last_answer = '0;
  end

  // one event a cycle; valid stays up so calls can run back to back
  task automatic send(input platform_id_pkg::event_kind_type kind,
                      input logic [7:0] data);
  begin
    o_event.valid = 1'b1;
    o_event.kind = kind;
    o_event.data = data;
    @(negedge i_clk);
    last_answer = i_answer; // answer lands one edge after taking
  end
  endtask

  // start carries the configured slave address and direction bit
  task automatic start(input logic [6:0] addr, input logic rd);
  begin
    send(platform_id_pkg::EV_START, {addr, rd});
  end
  endtask

  // release; data shows the inverse so a stale byte is never trusted
  task automatic idle(input int cycles);
  begin
    o_event.valid = 1'b0;
    o_event.data = ~o_event.data;
    repeat (cycles) @(negedge i_clk);
  end
  endtask
endmodule // host_event_model

// *** tb/tb_top.sv ***
// self-checking bench for the identification command responder
`timescale 1ns/10ps
`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  localparam logic [15:0] ID_WORD_VAL = 16'h5a3c; // arbitrary value
  localparam logic [47:0] ID_BLOCK_VAL = 48'h917a6b2c3d1e; // arbitrary value
  logic i_clk;
  logic i_rst_n;
  logic [6:0] i_slave_addr;
  platform_id_pkg::bus_event_type i_event;
  platform_id_pkg::answer_type o_answer;
  platform_id_pkg::answer_type ans;
  int num_errors;
  int n_compared;

  platform_id_command_responder #(
    .ID_WORD(ID_WORD_VAL),
    .ID_BLOCK(ID_BLOCK_VAL)
  ) i_platform_id_command_responder (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_slave_addr(i_slave_addr),
    .i_event(i_event),
    .o_answer(o_answer)
  );

  host_event_model i_host_event_model (
    .i_clk(i_clk),
    .i_answer(o_answer),
    .o_event(i_event)
  );

  // 100 MHz clock
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  task automatic report_and_stop;
  begin
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  // one event through the host model, answer kept in ans
  task automatic ev(input platform_id_pkg::event_kind_type k,
                    input logic [7:0] d);
  begin
    i_host_event_model.send(k, d);
    ans = i_host_event_model.last_answer;
  end
  endtask

  // full read of one command; n bytes expected, then one overrun read
  task automatic check_reply(input logic [7:0] cmd, input logic [55:0] exp,
                             input int n);
  begin
    i_host_event_model.start(i_slave_addr, 1'b0);
    ans = i_host_event_model.last_answer;
    `CHECK({ans.ack, ans.claim}, 2'b10)
    ev(platform_id_pkg::EV_WRITE, cmd);
    `CHECK({ans.ack, ans.claim}, 2'b11)
    i_host_event_model.start(i_slave_addr, 1'b1);
    ans = i_host_event_model.last_answer;
    `CHECK({ans.ack, ans.claim}, 2'b11)
    for (int k = 0; k < n; k++)
    begin
      ev(platform_id_pkg::EV_READ, 8'h00);
      `CHECK({ans.rd_valid, ans.cml_err, ans.rd_data}, {2'b10, exp[8*k +: 8]})
    end
    // reply length is fixed, so one more byte is an overrun
    ev(platform_id_pkg::EV_READ, 8'h00);
    `CHECK({ans.rd_valid, ans.cml_err, ans.rd_data}, {2'b11, platform_id_pkg::PAD_BYTE})
    ev(platform_id_pkg::EV_STOP, 8'h00);
    `CHECK(ans.claim, 1'b0)
    i_host_event_model.idle(1);
  end
  endtask

  task automatic test_reads;
  begin
    check_reply(platform_id_pkg::CMD_ID_WORD, {40'h0, ID_WORD_VAL}, 2);
    check_reply(platform_id_pkg::CMD_ID_BLOCK, {ID_BLOCK_VAL, platform_id_pkg::BLOCK_COUNT}, 7);
  end
  endtask

  // writes of both commands are acked silently and change nothing
  task automatic test_writes;
  begin
    for (int c = 0; c < 2; c++)
    begin
      i_host_event_model.start(i_slave_addr, 1'b0);
      ev(platform_id_pkg::EV_WRITE, c == 0 ? platform_id_pkg::CMD_ID_WORD
                                           : platform_id_pkg::CMD_ID_BLOCK);
      `CHECK({ans.ack, ans.cml_err}, 2'b10)
      for (int k = 0; k < (c == 0 ? 2 : 7); k++)
      begin
        ev(platform_id_pkg::EV_WRITE, k == 0 && c == 1 ? 8'h06 : 8'ha5 ^ 8'(k));
        `CHECK({ans.ack, ans.cml_err, ans.rd_valid}, 3'b100)
      end
      // a repeated start right after the dropped data reads the fixed value
      i_host_event_model.start(i_slave_addr, 1'b1);
      ans = i_host_event_model.last_answer;
      `CHECK({ans.ack, ans.claim}, 2'b11)
      ev(platform_id_pkg::EV_READ, 8'h00);
      if (c == 0)
        `CHECK(ans.rd_data, ID_WORD_VAL[7:0])
      else
        `CHECK(ans.rd_data, platform_id_pkg::BLOCK_COUNT)
      ev(platform_id_pkg::EV_STOP, 8'h00);
      `CHECK(ans.claim, 1'b0)
      i_host_event_model.idle(2);
    end
    check_reply(platform_id_pkg::CMD_ID_WORD, {40'h0, ID_WORD_VAL}, 2);
    check_reply(platform_id_pkg::CMD_ID_BLOCK, {ID_BLOCK_VAL, platform_id_pkg::BLOCK_COUNT}, 7);
  end
  endtask

  // foreign address, unknown command, and a reset in mid-transaction
  task automatic test_refused;
  begin
    i_host_event_model.start(i_slave_addr ^ 7'h01, 1'b0);
    `CHECK(i_host_event_model.last_answer.ack, 1'b0)
    ev(platform_id_pkg::EV_WRITE, platform_id_pkg::CMD_ID_WORD);
    `CHECK({ans.ack, ans.claim}, 2'b00)
    ev(platform_id_pkg::EV_READ, 8'h00);
    `CHECK(ans.rd_valid, 1'b0)
    ev(platform_id_pkg::EV_STOP, 8'h00);
    i_host_event_model.start(i_slave_addr, 1'b0);
    ev(platform_id_pkg::EV_WRITE, 8'hfe);
    `CHECK({ans.ack, ans.claim}, 2'b00)
    i_host_event_model.start(i_slave_addr, 1'b1);
    `CHECK(i_host_event_model.last_answer.ack, 1'b0)
    ev(platform_id_pkg::EV_STOP, 8'h00);
    i_host_event_model.start(i_slave_addr, 1'b0);
    ev(platform_id_pkg::EV_WRITE, platform_id_pkg::CMD_ID_BLOCK);
    i_host_event_model.idle(1);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    `CHECK(o_answer, 12'h000)
    i_rst_n = 1'b1;
    ev(platform_id_pkg::EV_READ, 8'h00);
    `CHECK({ans.rd_valid, ans.claim}, 2'b00)
    i_host_event_model.idle(1);
  end
  endtask

  // watchdog: the whole run needs about 160 cycles
  initial
  begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    report_and_stop();
  end

  // reset, then the scenarios under two slave addresses
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    i_slave_addr = 7'h2a;
    repeat (2) @(negedge i_clk);
    `CHECK(o_answer, 12'h000)
    i_rst_n = 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      i_slave_addr = a == 0 ? 7'h2a : 7'h55;
      test_reads();
      test_writes();
      test_refused();
    end
    report_and_stop();
  end
endmodule // tb_top
